// ### verilog/sysctl_regs.sv
`timescale 1ns/1ps
// ==========================================================
// System-control register bank for the pipeline's moves
// ==========================================================
module sysctl_regs
  import sysctl_pkg::*;
#(
  parameter int TLB_ENTRIES = 16  // Implemented TLB entries, 1 to 32
) (
  input wire logic ref_clk,                 // Core clock, 100 MHz
  input wire logic rst_n,                   // Async reset, active low
  input wire move_req_t req,                // Move to/from request
  input wire probe_res_t probe,             // tlb_probe_op result
  input wire logic tlb_read_op,             // Read entry at slot
  input wire logic tlb_write_at_slot_op,    // Write entry at slot
  input wire logic exc_enter,               // Exception taken
  input wire logic exc_return,              // Exception return
  input wire logic [IRQ_N-1:0] irq_lines,   // Interrupt pins
  output logic [31:0] rd_data,              // Read data
  output logic rd_valid,                    // Read data valid pulse
  output tlb_cmd_t tlb_cmd,                 // TLB access with slot
  output logic exception_level_bit,         // Exception level
  output logic irq_request                  // Unmasked interrupt
);

  // ==========================================================
  // Decode
  // ==========================================================
  logic hit_slot;    // Request names the slot selector
  logic hit_status;  // Request names status
  logic hit_force;   // Request names soft force
  logic hit_config;  // Request names configuration
  logic hit_scratch; // Request names scratch

  always_comb begin
    hit_slot = (req.reg_num == REG_SLOT) && (req.sel == SEL_SLOT);
    hit_status = (req.reg_num == REG_STATUS) && (req.sel == SEL_STATUS);
    hit_force = (req.reg_num == REG_FORCE) && (req.sel == SEL_FORCE);
    hit_config = (req.reg_num == REG_CONFIG) && (req.sel == SEL_CONFIG);
    hit_scratch = (req.reg_num == REG_SCRATCH) && (req.sel == SEL_SCRATCH);
  end

  logic wr;          // A move_to_sysctl this cycle
  logic rd;          // A move_from_sysctl this cycle
  assign wr = req.valid && req.write;
  assign rd = req.valid && !req.write;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] slot_value;    // Slot selector as read
  logic [31:0] status_value;  // Status stored
  logic [31:0] status_view;   // Status as read
  logic [31:0] force_value;   // Soft force stored
  logic [31:0] force_view;    // Soft force as read (zero)
  logic [31:0] config_value;  // Configuration stored
  logic [31:0] config_view;   // Configuration as read
  logic [31:0] scratch_value; // Scratch stored
  logic [31:0] scratch_view;  // Scratch as read
  logic status_hw_we;         // Exception entry or return
  logic [31:0] status_hw_data;

  tlb_slot_selector #(
    .ENTRIES(TLB_ENTRIES)
  ) u_slot (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sw_we(wr && hit_slot),
    .sw_wdata(req.wdata),
    .probe(probe),
    .value(slot_value)
  );

  // Entry sets the exception level, return clears it; entry wins
  always_comb begin
    status_hw_we = exc_enter || exc_return;
    status_hw_data = exc_enter ? ST_EXL_MASK : NO_BITS;
  end

  // status shared by software and hardware
  sysctl_field #(
    .RW_MASK(ST_RW_MASK),
    .WO_MASK(NO_BITS),
    .RO_MASK(NO_BITS),
    .RESET(ST_RESET)
  ) u_status (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sw_we(wr && hit_status),
    .sw_wdata(req.wdata),
    .hw_we(status_hw_we),
    .hw_mask(ST_EXL_MASK),
    .hw_data(status_hw_data),
    .value(status_value),
    .read_view(status_view)
  );

  // Write-only force bits raise interrupt lines 1:0 while set
  sysctl_field #(
    .RW_MASK(NO_BITS),
    .WO_MASK(FORCE_WO_MASK),
    .RO_MASK(NO_BITS),
    .RESET(NO_BITS)
  ) u_force (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sw_we(wr && hit_force),
    .sw_wdata(req.wdata),
    .hw_we(1'b0),
    .hw_mask(NO_BITS),
    .hw_data(NO_BITS),
    .value(force_value),
    .read_view(force_view)
  );

  localparam logic [31:0] CFG_PRESET = 32'(TLB_ENTRIES - 1);
  sysctl_field #(
    .RW_MASK(NO_BITS),
    .WO_MASK(NO_BITS),
    .RO_MASK(CFG_RO_MASK),
    .RESET(CFG_PRESET)
  ) u_config (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sw_we(wr && hit_config),
    .sw_wdata(req.wdata),
    .hw_we(1'b0),
    .hw_mask(NO_BITS),
    .hw_data(NO_BITS),
    .value(config_value),
    .read_view(config_view)
  );

  // Scratch is plain storage for kernel software
  sysctl_field #(
    .RW_MASK(SCRATCH_RW_MASK),
    .WO_MASK(NO_BITS),
    .RO_MASK(NO_BITS),
    .RESET(NO_BITS)
  ) u_scratch (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sw_we(wr && hit_scratch),
    .sw_wdata(req.wdata),
    .hw_we(1'b0),
    .hw_mask(NO_BITS),
    .hw_data(NO_BITS),
    .value(scratch_value),
    .read_view(scratch_view)
  );

  // ==========================================================
  // Read path
  // ==========================================================
  logic [31:0] next_rd_data;
  logic next_rd_valid;

  // Reads see the value before any write landing the same cycle
  always_comb begin
    next_rd_valid = rd;
    next_rd_data = 32'h0000_0000;
    if (rd) begin
      if (hit_slot) begin
        next_rd_data = slot_value;
      end else if (hit_status) begin
        next_rd_data = status_view;
      end else if (hit_force) begin
        next_rd_data = force_view;
      end else if (hit_config) begin
        next_rd_data = config_view;
      end else if (hit_scratch) begin
        next_rd_data = scratch_view;
      end else begin
        next_rd_data = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ==========================================================
  // TLB access command
  // ==========================================================
  tlb_cmd_t next_tlb_cmd;

  always_comb begin
    next_tlb_cmd.valid = tlb_read_op || tlb_write_at_slot_op;
    next_tlb_cmd.write = tlb_write_at_slot_op;
    next_tlb_cmd.slot = slot_value[SLOT_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tlb_cmd <= '0;
    end else begin
      tlb_cmd <= next_tlb_cmd;
    end
  end

  // ==========================================================
  // Interrupt gating
  // ==========================================================
  logic [IRQ_N-1:0] irq_meta;  // First synchroniser stage
  logic [IRQ_N-1:0] irq_sync;  // Second synchroniser stage
  logic [IRQ_N-1:0] irq_all;   // Pins plus forced lines
  logic next_irq_request;
  logic next_exl;

  // Pins are asynchronous to the core clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      irq_meta <= irq_lines;
      irq_sync <= irq_meta;
    end
  end

  always_comb begin
    irq_all = irq_sync;
    irq_all[1:0] = irq_sync[1:0] | force_value[1:0];
    next_irq_request = (|(irq_all & status_value[ST_IM_LO +: IRQ_N]))
                     && status_value[ST_IE_BIT] && !status_value[ST_EXL_BIT];
    next_exl = status_value[ST_EXL_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
      exception_level_bit <= 1'b1;
    end else begin
      irq_request <= next_irq_request;
      exception_level_bit <= next_exl;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_read_latency: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd |=> rd_valid ##1 !rd_valid || $past(rd))
    else $error("read answer not a single-cycle pulse");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd && !(hit_slot || hit_status || hit_force || hit_config || hit_scratch))
      |=> (rd_valid && rd_data == 32'h0000_0000))
    else $error("unmapped register read nonzero");

  a_irq_exl_block: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (status_value[ST_EXL_BIT] || !status_value[ST_IE_BIT]) |=> !irq_request)
    else $error("interrupt raised while blocked");

  a_slot_middle_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (rd && hit_slot) |=> (rd_data[30:SLOT_W] == '0))
    else $error("slot selector middle bits nonzero");

  a_exl_entry: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    exc_enter |=> ##1 exception_level_bit)
    else $error("exception level not set after entry");

endmodule

// ### verilog/sysctl_pkg.sv
package sysctl_pkg;

  // ==========================================================
  // Register numbers and selects
  // ==========================================================
  localparam logic [4:0] REG_SLOT = 5'h00;    // Slot selector
  localparam logic [4:0] REG_STATUS = 5'h0c;  // Status and masks
  localparam logic [4:0] REG_FORCE = 5'h0d;   // Soft interrupt force
  localparam logic [4:0] REG_CONFIG = 5'h10;  // Build-time configuration
  localparam logic [4:0] REG_SCRATCH = 5'h1f; // Kernel scratch
  localparam logic [2:0] SEL_SLOT = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_FORCE = 3'h0;
  localparam logic [2:0] SEL_CONFIG = 3'h1;
  localparam logic [2:0] SEL_SCRATCH = 3'h2;

  // ==========================================================
  // Field layouts
  // ==========================================================
  localparam int SLOT_W = 5;          // Slot field bits 4:0
  localparam int SLOT_FAIL_BIT = 31;  // Probe-miss flag
  localparam int ST_IE_BIT = 0;       // Global enable
  localparam int ST_EXL_BIT = 1;      // Exception level
  localparam int ST_IM_LO = 8;        // Line masks 15:8
  localparam int IRQ_N = 8;           // Interrupt lines
  localparam logic [31:0] ST_RW_MASK = 32'h0000_ff03;
  localparam logic [31:0] ST_EXL_MASK = 32'h0000_0002;
  localparam logic [31:0] ST_RESET = 32'h0000_0002;
  localparam logic [31:0] FORCE_WO_MASK = 32'h0000_0003;
  localparam logic [31:0] CFG_RO_MASK = 32'h0000_003f;
  localparam logic [31:0] SCRATCH_RW_MASK = 32'hffff_ffff;
  localparam logic [31:0] NO_BITS = 32'h0000_0000;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic valid;        // Move request present
    logic write;        // 1 move_to_sysctl, 0 move_from_sysctl
    logic [4:0] reg_num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } move_req_t;

  typedef struct packed {
    logic valid;        // tlb_probe_op finished
    logic hit;          // An entry matched
    logic [SLOT_W-1:0] slot;
  } probe_res_t;

  typedef struct packed {
    logic valid;        // TLB access issued
    logic write;        // 1 tlb_write_at_slot_op, 0 tlb_read_op
    logic [SLOT_W-1:0] slot;
  } tlb_cmd_t;

endpackage

// ### verilog/sysctl_field.sv
`timescale 1ns/1ps
// ==========================================================
// Generic register with per-bit access classes
// ==========================================================
module sysctl_field
  import sysctl_pkg::*;
#(
  parameter logic [31:0] RW_MASK = 32'h0000_0000,
  parameter logic [31:0] WO_MASK = 32'h0000_0000,
  parameter logic [31:0] RO_MASK = 32'h0000_0000,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  input wire logic ref_clk,          // Core clock
  input wire logic rst_n,            // Async reset, active low
  input wire logic sw_we,            // Software write strobe
  input wire logic [31:0] sw_wdata,  // Software write data
  input wire logic hw_we,            // Hardware load strobe
  input wire logic [31:0] hw_mask,   // Bits hardware loads
  input wire logic [31:0] hw_data,   // Hardware load data
  output logic [31:0] value,         // Stored value
  output logic [31:0] read_view      // What software reads
);

  logic [31:0] next_value; // Next stored value

  // ==========================================================
  // Update
  // ==========================================================
  // Hardware is applied last so an event beats a same-cycle write
  always_comb begin
    next_value = value;
    if (sw_we) begin
      next_value = (value & ~(RW_MASK | WO_MASK)) | (sw_wdata & (RW_MASK | WO_MASK));
    end
    if (hw_we) begin
      next_value = (next_value & ~(hw_mask & (RW_MASK | RO_MASK)))
                 | (hw_data & hw_mask & (RW_MASK | RO_MASK));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET & (RW_MASK | WO_MASK | RO_MASK);
    end else begin
      value <= next_value;
    end
  end

  // zero and write-only bits read zero
  assign read_view = value & (RW_MASK | RO_MASK);

  a_zero_field: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (value & ~(RW_MASK | WO_MASK | RO_MASK)) == 32'h0000_0000)
    else $error("constant-zero bit became set");

  a_ro_ignores: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sw_we && !hw_we) |=> ((value & RO_MASK) == ($past(value) & RO_MASK)))
    else $error("read-only bits changed by software write");

  a_wo_reads_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sw_we |=> (((value & WO_MASK) == ($past(sw_wdata) & WO_MASK))
      && ((read_view & WO_MASK) == 32'h0000_0000)))
    else $error("write-only bits not stored or visible on read");

endmodule

// ### verilog/tlb_slot_selector.sv
`timescale 1ns/1ps
// ==========================================================
// TLB slot selector: probe-miss flag and slot field
// ==========================================================
module tlb_slot_selector
  import sysctl_pkg::*;
#(
  parameter int ENTRIES = 16  // Implemented TLB entries, at most 32
) (
  input wire logic ref_clk,          // Core clock
  input wire logic rst_n,            // Async reset, active low
  input wire logic sw_we,            // Software write strobe
  input wire logic [31:0] sw_wdata,  // Software write data
  input wire probe_res_t probe,      // Probe result
  output logic [31:0] value          // Register as read
);

  logic fail;                    // Probe-miss flag
  logic [SLOT_W-1:0] slot;       // Slot field
  logic next_fail;
  logic [SLOT_W-1:0] next_slot;
  localparam logic [SLOT_W:0] LIMIT = (SLOT_W + 1)'(ENTRIES);

  // ==========================================================
  // Update
  // ==========================================================
  always_comb begin
    next_fail = fail;
    next_slot = slot;
    if (sw_we && ({1'b0, sw_wdata[SLOT_W-1:0]} < LIMIT)) begin
      next_slot = sw_wdata[SLOT_W-1:0];
    end
    // A probe completing with a write lands after it
    if (probe.valid) begin
      next_fail = ~probe.hit;
      if (probe.hit) begin
        next_slot = probe.slot;
      end
    end
  end

  // Undefined at power-up; zero keeps simulation deterministic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail <= 1'b0;
      slot <= '0;
    end else begin
      fail <= next_fail;
      slot <= next_slot;
    end
  end

  assign value = {fail, {(31 - SLOT_W){1'b0}}, slot};

  a_slot_keep_big: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sw_we && !probe.valid && ({1'b0, sw_wdata[SLOT_W-1:0]} >= LIMIT)) |=> $stable(slot))
    else $error("slot changed by out-of-range write");

  a_probe_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    probe.valid |=> (fail == !$past(probe.hit)))
    else $error("probe flag wrong after probe");

  a_probe_miss_slot: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (probe.valid && !probe.hit && !sw_we) |=> $stable(slot))
    else $error("slot loaded by missing probe");

endmodule

// ### tb/pipeline_model.sv
`timescale 1ns/1ps
// ==========================================================
// Pipeline side: moves, probe results and TLB accesses
// ==========================================================
module pipeline_model
  import sysctl_pkg::*;
(
  input wire logic ref_clk,           // Core clock
  input wire logic [31:0] rd_data,    // Read data from the bank
  input wire logic rd_valid,          // Read data valid pulse
  output move_req_t req,              // Move request
  output probe_res_t probe,           // Probe result
  output logic tlb_read_op,           // Read entry at slot
  output logic tlb_write_at_slot_op,  // Write entry at slot
  output logic exc_enter,             // Exception taken
  output logic exc_return             // Exception return
);
  // Everything idle from time zero
  initial begin
    req = '0;
    probe = '0;
    tlb_read_op = 1'b0;
    tlb_write_at_slot_op = 1'b0;
    exc_enter = 1'b0;
    exc_return = 1'b0;
  end

  // hazard gap kept
  // One idle cycle after every write, so a read never races the update
  task automatic mv_to(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b1, r, s, d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // Read: wait a few cycles at most for the valid pulse
  task automatic mv_from(input logic [4:0] r, input logic [2:0] s, output logic [31:0] d);
    int n;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, r, s, 32'h0};
    @(posedge ref_clk);
    req <= '0;
    n = 0;
    #1;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A missing answer shows as a value no check in this bench expects
    d = (rd_valid === 1'b1) ? rd_data : 32'hdead_beef;
  endtask

  // Probe result pulse; a miss carries a junk slot on purpose
  task automatic do_probe(input logic hit, input logic [4:0] slot);
    @(posedge ref_clk);
    probe <= '{1'b1, hit, slot};
    @(posedge ref_clk);
    probe <= '0;
  endtask

  // TLB access pulse, returns on the edge that takes it
  task automatic do_tlb(input logic wr);
    @(posedge ref_clk);
    tlb_write_at_slot_op <= wr;
    tlb_read_op <= !wr;
    @(posedge ref_clk);
    tlb_write_at_slot_op <= 1'b0;
    tlb_read_op <= 1'b0;
  endtask

  // Exception entry or return pulse
  task automatic do_exc(input logic enter);
    @(posedge ref_clk);
    exc_enter <= enter;
    exc_return <= !enter;
    @(posedge ref_clk);
    exc_enter <= 1'b0;
    exc_return <= 1'b0;
  endtask
endmodule

// ### tb/system_control_register_access_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the system-control register bank
// ==========================================================
module system_control_register_access_tb;
  import sysctl_pkg::*;
  // Fewer entries than slots, so the refused range is reachable
  localparam int ENT = 12;
  logic ref_clk;                  // Core clock
  logic rst_n;                    // Reset, active low
  logic [7:0] irq_lines;          // Interrupt pins
  move_req_t req;                 // Move request
  probe_res_t probe;              // Probe result
  logic tlb_read_op;              // Read entry strobe
  logic tlb_write_at_slot_op;     // Write entry strobe
  logic exc_enter;                // Exception taken
  logic exc_return;               // Exception return
  logic [31:0] rd_data;           // Read data
  logic rd_valid;                 // Read valid
  tlb_cmd_t tlb_cmd;              // TLB access out
  logic exception_level_bit;      // Exception level out
  logic irq_request;              // Interrupt out
  int errors = 0;                 // Mismatches
  int compares = 0;               // Comparisons
  int cycles = 0;                 // Hang guard
  logic [31:0] d;                 // Read result

  sysctl_regs #(.TLB_ENTRIES(ENT)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
    .probe(probe), .tlb_read_op(tlb_read_op), .tlb_write_at_slot_op(tlb_write_at_slot_op),
    .exc_enter(exc_enter), .exc_return(exc_return), .irq_lines(irq_lines),
    .rd_data(rd_data), .rd_valid(rd_valid), .tlb_cmd(tlb_cmd),
    .exception_level_bit(exception_level_bit), .irq_request(irq_request));
  pipeline_model model_u (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .req(req), .probe(probe), .tlb_read_op(tlb_read_op),
    .tlb_write_at_slot_op(tlb_write_at_slot_op), .exc_enter(exc_enter),
    .exc_return(exc_return));

  // ==========================================================
  // Clock, hang guard, comparison and verdict
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run is about 130 cycles; this ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Interrupt output is synchronised, so give it time to land
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h0); // slot after reset
    model_u.mv_from(REG_STATUS, SEL_STATUS, d);
    chk(d, ST_RESET); // status reset value
    model_u.mv_from(REG_CONFIG, SEL_CONFIG, d);
    chk(d, 32'(ENT - 1)); // preset config field
    chk({31'h0, exception_level_bit}, 32'h1); // blocked after reset
  endtask

  task automatic t_access();
    model_u.mv_to(REG_CONFIG, SEL_CONFIG, 32'hffff_ffff);
    model_u.mv_from(REG_CONFIG, SEL_CONFIG, d);
    chk(d, 32'(ENT - 1)); // read-only ignores write
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'hffff_fffc);
    model_u.mv_from(REG_STATUS, SEL_STATUS, d);
    chk(d, 32'h0000_ff00); // zero bits drop writes
    model_u.mv_to(REG_SCRATCH, SEL_SCRATCH, 32'ha5a5_5a5a);
    model_u.mv_from(REG_SCRATCH, SEL_SCRATCH, d);
    chk(d, 32'ha5a5_5a5a); // written value readable
    model_u.mv_to(REG_FORCE, SEL_FORCE, 32'h0000_0003);
    model_u.mv_from(REG_FORCE, SEL_FORCE, d);
    chk(d, 32'h0); // write-only reads zero
    model_u.mv_to(REG_FORCE, SEL_FORCE, 32'h0);
  endtask

  task automatic t_slot();
    model_u.mv_to(REG_SLOT, SEL_SLOT, 32'hffff_ffe3);
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h0000_0003); // middle bits read zero
    model_u.mv_to(REG_SLOT, SEL_SLOT, 32'(ENT));
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h0000_0003); // first refused value
    model_u.mv_to(REG_SLOT, SEL_SLOT, 32'(ENT - 1));
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'(ENT - 1)); // top entry accepted
  endtask

  task automatic t_probe();
    model_u.do_probe(1'b1, 5'h07);
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h0000_0007); // hit loads slot
    model_u.do_tlb(1'b0);
    #1;
    chk({25'h0, tlb_cmd}, 32'h0000_0047); // read uses slot
    model_u.do_probe(1'b0, 5'h18);
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h8000_0007); // miss sets flag
    model_u.do_tlb(1'b1);
    #1;
    chk({25'h0, tlb_cmd}, 32'h0000_0067); // write uses slot
    @(posedge ref_clk);
    #1;
    chk({31'h0, tlb_cmd.valid}, 32'h0); // command is a single pulse
    model_u.do_probe(1'b1, 5'h02);
    model_u.mv_from(REG_SLOT, SEL_SLOT, d);
    chk(d, 32'h0000_0002); // hit clears flag
  endtask

  task automatic t_unmapped();
    logic [7:0] pairs [4];
    pairs = '{8'h08, 8'h01, 8'ha0, 8'hf8};
    // Reserved, wrong select and unused numbers all behave as empty
    foreach (pairs[i]) begin
      model_u.mv_to(pairs[i][7:3], pairs[i][2:0], 32'hffff_ffff);
      model_u.mv_from(pairs[i][7:3], pairs[i][2:0], d);
      chk(d, 32'h0); // unmapped pair reads zero
    end
    model_u.mv_from(REG_SCRATCH, SEL_SCRATCH, d);
    chk(d, 32'ha5a5_5a5a); // neighbour select untouched
  endtask

  task automatic t_irq();
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'h0000_0801);
    irq_lines <= 8'h08;
    settle();
    chk({31'h0, irq_request}, 32'h1); // enabled line passes
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'h0000_0001);
    settle();
    chk({31'h0, irq_request}, 32'h0); // line mask blocks
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'h0000_0800);
    settle();
    chk({31'h0, irq_request}, 32'h0); // global enable blocks
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'h0000_0801);
    model_u.do_exc(1'b1);
    settle();
    chk({30'h0, exception_level_bit, irq_request}, 32'h2); // exception level blocks
    model_u.do_exc(1'b0);
    settle();
    chk({30'h0, exception_level_bit, irq_request}, 32'h1); // hardware clear seen
    model_u.mv_to(REG_STATUS, SEL_STATUS, 32'h0000_0101);
    irq_lines <= 8'h00;
    model_u.mv_to(REG_FORCE, SEL_FORCE, 32'h0000_0001);
    settle();
    chk({31'h0, irq_request}, 32'h1); // write-only bit takes effect
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    irq_lines = 8'h00;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_access();
    t_slot();
    t_probe();
    t_unmapped();
    t_irq();
    give_verdict();
  end
endmodule
